// [logic/mhb_pkg.sv]
// mhb_pkg: constants, configuration layout and carriers of the multiplexed host port.
// assumes: one 100 MHz clock, classic wishbone register access, 8-bit byte-address bus.
package mhb_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////
    // register map (byte addresses on the wishbone side)
    localparam logic [7:0]  MHB_OFS_CONFIG   = 8'h00;
    localparam logic [7:0]  MHB_OFS_STATUS   = 8'h04;
    localparam logic [7:0]  MHB_OFS_COUNT    = 8'h08;
    localparam logic [1:0]  MHB_MEM_SEL      = 2'h1;   // adr[7:6] == 1 -> 0x40..0x7c
    localparam int          MHB_MEM_WORDS    = 16;
    localparam logic [31:0] MHB_MEM_RESET    = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////////////
    // process_data_port_config field positions
    localparam int MHB_CFG_HOLD_POL  = 0;   // 1: hold-off output asserts high
    localparam int MHB_CFG_ALE_POL   = 1;   // 1: latch strobes active high
    localparam int MHB_CFG_CS_POL    = 2;   // 1: device select active high
    localparam int MHB_CFG_RD_POL    = 3;   // read strobe / direction polarity
    localparam int MHB_CFG_WR_POL    = 4;   // write strobe / enable polarity
    localparam int MHB_CFG_RW_MODE   = 5;   // 1: direction line plus access_strobe_line
    localparam int MHB_CFG_ALE_QUAL  = 6;   // 1: latch strobes need device select
    localparam int MHB_CFG_SINGLE    = 7;   // 1: single-phase address latching
    localparam int MHB_CFG_BUS16     = 8;   // 1: 16-bit data, 0: 8-bit data
    localparam int MHB_CFG_HOLD_OE   = 9;   // 1: hold-off pin enabled as output
    localparam int MHB_CFG_WIDTH     = 10;
    localparam logic [9:0] MHB_CFG_RESET = 10'h01e;   // active-high strobes, 8-bit, dual

    ////////////////////////////////////////////////////////////////////////////////////////
    // counters and latched address
    localparam logic [15:0] MHB_ADDR_RESET = 16'h0000;
    localparam logic [15:0] MHB_CNT_RESET  = 16'h0000;

    // configuration as a carrier
    typedef struct packed {
        logic hold_oe;
        logic bus16;
        logic single;
        logic ale_qual;
        logic rw_mode;
        logic wr_pol;
        logic rd_pol;
        logic cs_pol;
        logic ale_pol;
        logic hold_pol;
    } mhb_cfg_t;

    // synchronised host control lines
    typedef struct packed {
        logic ale_hi;
        logic ale_lo;
        logic cs;
        logic rd;
        logic wr;
        logic endian;
    } mhb_ctl_t;

    // decoded, polarity-corrected bus phase
    typedef struct packed {
        logic lat_hi;
        logic lat_lo;
        logic rd;
        logic wr;
    } mhb_phase_t;

endpackage

// [logic/mhb_top.sv]
// mhb_top: multiplexed address/data host port in compatibility mode, with a small
// internal dword store that the host reaches over the pins and software over wishbone.
// assumes: host pins are asynchronous and pass two flops; host strobes last several clocks.
`timescale 1ns/1ps
module mhb_top
    import mhb_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire logic        NRST,
    // classic wishbone slave
    input  wire logic        WB_CYC,
    input  wire logic        WB_STB,
    input  wire logic        WB_WE,
    input  wire logic [7:0]  WB_ADR,
    input  wire logic [3:0]  WB_SEL,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK,
    // host pins
    input  wire logic [15:0] AD_IN,
    output logic      [15:0] AD_OUT,
    output logic      [1:0]  AD_OE,
    input  wire logic [7:0]  DHI_IN,
    output logic      [7:0]  DHI_OUT,
    output logic             DHI_OE,
    input  wire logic        ADDRESS_LATCH_HIGH_STROBE,
    input  wire logic        ADDRESS_LATCH_LOW_STROBE,
    input  wire logic        CS,
    input  wire logic        RD,
    input  wire logic        WR,
    input  wire logic [1:0]  BYTE_LANE_ENABLES,
    input  wire logic        ENDIAN_SEL,
    output logic             HOLD_OUT,
    output logic             HOLD_OE
);

    ////////////////////////////////////////////////////////////////////////////////////////
    // functions

    // internal byte index for a host lane; store is little-endian
    function automatic logic [1:0] byte_sel(input logic [1:0] a, input logic big,
                                            input logic bus16, input logic hi);
        logic [1:0] r;
        if (bus16) begin
            r = {a[1] ^ big, hi};
        end else begin
            r = big ? ~a : a;
        end
        return r;
    endfunction

    // polarity-corrected phase decode, shared by the current and previous sample
    function automatic mhb_phase_t decode(input mhb_ctl_t c, input mhb_cfg_t g);
        mhb_phase_t p;
        logic       sel;
        logic       en;
        sel      = (c.cs == g.cs_pol);
        // select gating of the latch strobes is optional
        p.lat_lo = (c.ale_lo == g.ale_pol) && (!g.ale_qual || sel);
        p.lat_hi = (c.ale_hi == g.ale_pol) && (!g.ale_qual || sel) && !g.single;
        if (g.rw_mode) begin
            // direction line equal to its polarity bit means write
            en   = (c.wr == g.wr_pol);
            p.wr = sel && en && (c.rd == g.rd_pol);
            p.rd = sel && en && (c.rd != g.rd_pol);
        end else begin
            p.wr = sel && (c.wr == g.wr_pol);
            p.rd = sel && (c.rd == g.rd_pol);
        end
        return p;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // declarations
    mhb_cfg_t    cfg_q, cfg_d;
    mhb_ctl_t    ctl_s1_q, ctl_s2_q, ctl_p_q;
    logic [15:0] ad_s1_q, ad_s2_q, ad_p_q;
    logic [7:0]  dhi_s1_q, dhi_s2_q, dhi_p_q;
    mhb_ctl_t    ctl_raw;
    mhb_phase_t  ph_now, ph_prev;

    logic [7:0]  addr_lo_q, addr_lo_d;
    logic [7:0]  addr_hi_q, addr_hi_d;
    logic        endian_q, endian_d;
    logic [15:0] addr;

    logic [31:0] mem_q [MHB_MEM_WORDS];
    logic [31:0] mem_d [MHB_MEM_WORDS];
    logic [15:0] rd_cnt_q, rd_cnt_d;
    logic [15:0] wr_cnt_q, wr_cnt_d;

    logic [15:0] ad_out_q, ad_out_d;
    logic [1:0]  ad_oe_q, ad_oe_d;
    logic [7:0]  dhi_out_q, dhi_out_d;
    logic        dhi_oe_q, dhi_oe_d;
    logic        hold_q, hold_d;
    logic        hold_oe_q, hold_oe_d;

    logic        ack_q, ack_d;
    logic [31:0] wb_dat_q, wb_dat_d;
    logic        wb_req;

    ////////////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; the byte_lane_enables never enter the logic
    assign ctl_raw = '{ale_hi: ADDRESS_LATCH_HIGH_STROBE, ale_lo: ADDRESS_LATCH_LOW_STROBE,
                       cs: CS, rd: RD, wr: WR, endian: ENDIAN_SEL};

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            ctl_s1_q <= '0;
            ctl_s2_q <= '0;
            ctl_p_q  <= '0;
            ad_s1_q  <= '0;
            ad_s2_q  <= '0;
            ad_p_q   <= '0;
            dhi_s1_q <= '0;
            dhi_s2_q <= '0;
            dhi_p_q  <= '0;
        end else begin
            ctl_s1_q <= ctl_raw;
            ctl_s2_q <= ctl_s1_q;
            ctl_p_q  <= ctl_s2_q;   // one more stage: trailing edges and their data
            ad_s1_q  <= AD_IN;
            ad_s2_q  <= ad_s1_q;
            ad_p_q   <= ad_s2_q;
            dhi_s1_q <= DHI_IN;
            dhi_s2_q <= dhi_s1_q;
            dhi_p_q  <= dhi_s2_q;
        end
    end

    // phases seen now and one cycle ago; a trailing edge is prev & ~now
    assign ph_now  = decode(ctl_s2_q, cfg_q);
    assign ph_prev = decode(ctl_p_q, cfg_q);

    ////////////////////////////////////////////////////////////////////////////////////////
    // address latches: sampled at the strobe's trailing edge, held otherwise
    always_comb begin
        addr_lo_d = addr_lo_q;   // skipped phases keep the old halves
        addr_hi_d = addr_hi_q;
        endian_d  = endian_q;
        if (ph_prev.lat_lo && !ph_now.lat_lo) begin
            addr_lo_d = ad_p_q[7:0];
            endian_d  = ctl_p_q.endian;
            if (cfg_q.single) begin
                addr_hi_d = ad_p_q[15:8];                // whole address at once
            end
        end
        // high half from the low lane, independent of the low phase order
        if (ph_prev.lat_hi && !ph_now.lat_hi) begin
            addr_hi_d = ad_p_q[7:0];
            endian_d  = ctl_p_q.endian;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            addr_lo_q <= MHB_ADDR_RESET[7:0];
            addr_hi_q <= MHB_ADDR_RESET[15:8];
            endian_q  <= 1'b0;
        end else begin
            addr_lo_q <= addr_lo_d;
            addr_hi_q <= addr_hi_d;
            endian_q  <= endian_d;
        end
    end

    assign addr = {addr_hi_q, addr_lo_q};

    ////////////////////////////////////////////////////////////////////////////////////////
    // store: wishbone writes first, host write commit overrides per byte
    // parts of a dword land independently, so any order works
    always_comb begin
        logic [3:0] widx;
        logic [4:0] blo;
        logic [4:0] bhi;
        logic [7:0] hi_data;
        widx    = addr[5:2];
        blo     = {byte_sel(addr[1:0], endian_q, cfg_q.bus16, 1'b0), 3'h0};
        bhi     = {byte_sel(addr[1:0], endian_q, cfg_q.bus16, 1'b1), 3'h0};
        hi_data = cfg_q.single ? ad_p_q[15:8] : dhi_p_q;
        rd_cnt_d = rd_cnt_q;
        wr_cnt_d = wr_cnt_q;
        for (int i = 0; i < MHB_MEM_WORDS; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (wb_req && !ack_q && WB_WE && WB_ADR[7:6] == MHB_MEM_SEL) begin
            for (int b = 0; b < 4; b++) begin
                if (WB_SEL[b]) begin
                    mem_d[WB_ADR[5:2]][8*b +: 8] = WB_DAT_I[8*b +: 8];
                end
            end
        end
        // host write commits at the trailing edge of the write phase
        if (ph_prev.wr && !ph_now.wr) begin
            mem_d[widx][blo +: 8] = ad_p_q[7:0];
            if (cfg_q.bus16) begin
                mem_d[widx][bhi +: 8] = hi_data;         // 8-bit mode ignores upper pins
            end
            wr_cnt_d = wr_cnt_q + 16'h0001;
        end
        if (ph_now.rd && !ph_prev.rd) begin
            rd_cnt_d = rd_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            for (int i = 0; i < MHB_MEM_WORDS; i++) begin
                mem_q[i] <= MHB_MEM_RESET;
            end
            rd_cnt_q <= MHB_CNT_RESET;
            wr_cnt_q <= MHB_CNT_RESET;
        end else begin
            for (int i = 0; i < MHB_MEM_WORDS; i++) begin
                mem_q[i] <= mem_d[i];
            end
            rd_cnt_q <= rd_cnt_d;
            wr_cnt_q <= wr_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // host data drive; lanes only, the timing is the same for either endianness
    always_comb begin
        logic [31:0] word;
        logic [1:0]  ilo;
        logic [1:0]  ihi;
        word      = mem_q[addr[5:2]];
        ilo       = byte_sel(addr[1:0], endian_q, cfg_q.bus16, 1'b0);
        ihi       = byte_sel(addr[1:0], endian_q, cfg_q.bus16, 1'b1);
        ad_out_d  = 16'h0000;
        ad_oe_d   = 2'h0;
        dhi_out_d = 8'h00;
        dhi_oe_d  = 1'b0;
        if (ph_now.rd) begin
            ad_out_d[7:0] = word[{ilo, 3'h0} +: 8];
            ad_oe_d[0]    = 1'b1;
            if (cfg_q.bus16 && cfg_q.single) begin
                ad_out_d[15:8] = word[{ihi, 3'h0} +: 8];
                ad_oe_d[1]     = 1'b1;
            end else if (cfg_q.bus16) begin
                dhi_out_d = word[{ihi, 3'h0} +: 8];
                dhi_oe_d  = 1'b1;
            end
            // 8-bit modes leave the upper lane and upper pins undriven
        end
        // no wait states in this mode: hold-off sits at acknowledge
        hold_d    = !cfg_q.hold_pol;
        hold_oe_d = cfg_q.hold_oe;
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            ad_out_q  <= 16'h0000;
            ad_oe_q   <= 2'h0;
            dhi_out_q <= 8'h00;
            dhi_oe_q  <= 1'b0;
            hold_q    <= !MHB_CFG_RESET[MHB_CFG_HOLD_POL];
            hold_oe_q <= MHB_CFG_RESET[MHB_CFG_HOLD_OE];
        end else begin
            ad_out_q  <= ad_out_d;
            ad_oe_q   <= ad_oe_d;
            dhi_out_q <= dhi_out_d;
            dhi_oe_q  <= dhi_oe_d;
            hold_q    <= hold_d;
            hold_oe_q <= hold_oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // wishbone slave: one wait state, ack for every address, zero for unmapped reads
    assign wb_req = WB_CYC && WB_STB;

    always_comb begin
        ack_d    = wb_req && !ack_q;
        cfg_d    = cfg_q;
        wb_dat_d = 32'h0000_0000;
        if (wb_req && !ack_q) begin
            if (WB_ADR[7:2] == MHB_OFS_CONFIG[7:2]) begin
                wb_dat_d[MHB_CFG_WIDTH-1:0] = cfg_q;
                if (WB_WE && WB_SEL[0]) begin
                    cfg_d[7:0] = WB_DAT_I[7:0];
                end
                if (WB_WE && WB_SEL[1]) begin
                    cfg_d[9:8] = WB_DAT_I[9:8];
                end
            end else if (WB_ADR[7:2] == MHB_OFS_STATUS[7:2]) begin
                wb_dat_d[15:0] = addr;
                wb_dat_d[16]   = endian_q;
            end else if (WB_ADR[7:2] == MHB_OFS_COUNT[7:2]) begin
                wb_dat_d = {wr_cnt_q, rd_cnt_q};
            end else if (WB_ADR[7:6] == MHB_MEM_SEL) begin
                wb_dat_d = mem_q[WB_ADR[5:2]];
            end
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            cfg_q    <= MHB_CFG_RESET;
            ack_q    <= 1'b0;
            wb_dat_q <= 32'h0000_0000;
        end else begin
            cfg_q    <= cfg_d;
            ack_q    <= ack_d;
            wb_dat_q <= wb_dat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign WB_ACK   = ack_q;
    assign WB_DAT_O = wb_dat_q;
    assign AD_OUT   = ad_out_q;
    assign AD_OE    = ad_oe_q;
    assign DHI_OUT  = dhi_out_q;
    assign DHI_OE   = dhi_oe_q;
    assign HOLD_OUT = hold_q;
    assign HOLD_OE  = hold_oe_q;

endmodule

// [dv/mhb_top_asserts.sv]
// mhb_top_asserts: port-level checks of the multiplexed host port.
// assumes: bound to mhb_top; config is shadowed from wishbone writes.
`timescale 1ns/1ps
module mhb_chk
    import mhb_pkg::*;
(
    input wire logic        CLOCK,
    input wire logic        NRST,
    input wire logic        WB_CYC,
    input wire logic        WB_STB,
    input wire logic        WB_WE,
    input wire logic [7:0]  WB_ADR,
    input wire logic [3:0]  WB_SEL,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK,
    input wire logic [1:0]  AD_OE,
    input wire logic        DHI_OE,
    input wire logic        CS,
    input wire logic        RD,
    input wire logic        WR,
    input wire logic        HOLD_OUT,
    input wire logic        HOLD_OE
);
    logic [9:0] cfg_q;
    logic [9:0] cfg_d;
    logic       rd_ph;

    ////////////////////////////////////////////////////////////////////////////////
    // config shadow; a missed write here would skew the hold, lane and read-phase checks below
    always_comb begin
        cfg_d = cfg_q;
        if (WB_CYC && WB_STB && WB_WE && !WB_ACK && WB_ADR[7:2] == 6'h00) begin
            if (WB_SEL[0]) cfg_d[7:0] = WB_DAT_I[7:0];
            if (WB_SEL[1]) cfg_d[9:8] = WB_DAT_I[9:8];
        end
    end
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            cfg_q <= MHB_CFG_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end
    // qualified read phase at the pins, either strobe scheme
    assign rd_ph = (CS == cfg_q[2]) &&
                   (cfg_q[5] ? (RD != cfg_q[3] && WR == cfg_q[4]) : RD == cfg_q[3]);

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    AST_HOLD_LEVEL: assert property (HOLD_OE |-> HOLD_OUT == !$past(cfg_q[0]))
        else $error("hold-off left its acknowledge level");
    AST_HOLD_EN: assert property (HOLD_OE == $past(cfg_q[9]))
        else $error("hold-off enable does not follow config");
    AST_ACK_ONE: assert property (WB_ACK |=> !WB_ACK)
        else $error("ack longer than one cycle");
    AST_ACK_NEXT: assert property (WB_CYC && WB_STB && !WB_ACK |=> WB_ACK)
        else $error("request not answered next cycle");
    AST_DATO_IDLE: assert property (!WB_ACK |-> WB_DAT_O == 32'h0000_0000)
        else $error("read data outside ack");
    AST_UPPER_AD: assert property (AD_OE[1] |-> cfg_q[8] && cfg_q[7])
        else $error("upper muxed lane driven outside single 16-bit");
    AST_DHI_DUAL16: assert property (DHI_OE |-> cfg_q[8] && !cfg_q[7])
        else $error("upper data pins driven outside dual 16-bit");
    AST_DUAL16_BOTH: assert property (AD_OE[0] && cfg_q[8] && !cfg_q[7] |-> DHI_OE)
        else $error("dual 16-bit read drives one lane only");
    AST_OE_CAUSE: assert property ($rose(AD_OE[0]) |-> $past(rd_ph, 2))
        else $error("bus driven without a read phase");
    AST_OE_RELEASE: assert property ($fell(rd_ph) |-> ##[1:6] AD_OE == 2'h0)
        else $error("bus still driven after read phase");
endmodule

bind mhb_top mhb_chk u_chk (
    .CLOCK(CLOCK), .NRST(NRST), .WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_WE(WB_WE),
    .WB_ADR(WB_ADR), .WB_SEL(WB_SEL), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK(WB_ACK), .AD_OE(AD_OE), .DHI_OE(DHI_OE), .CS(CS), .RD(RD), .WR(WR),
    .HOLD_OUT(HOLD_OUT), .HOLD_OE(HOLD_OE));

// [dv/mhb_host.sv]
// mhb_host: behavioural host on the muxed address/data pins.
// assumes: driven by bench tasks; pins move just after a rising edge.
`timescale 1ns/1ps
module mhb_host (
    input  wire logic   clk,
    output logic        ale_hi,
    output logic        ale_lo,
    output logic        cs,
    output logic        rd,
    output logic        wr,
    output logic        endian,
    output logic [1:0]  ble,
    output logic [15:0] ad_o,
    output logic [1:0]  ad_en,
    output logic [7:0]  dhi_o,
    output logic        dhi_en
);
    logic ale_p = 1'b1, cs_p = 1'b1, rd_p = 1'b1, wr_p = 1'b1, rw_m = 1'b0, keep_hi = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // all control lines to their inactive level
    task automatic idle();
        ale_hi <= ~ale_p;
        ale_lo <= ~ale_p;
        cs     <= ~cs_p;
        rd     <= ~rd_p;
        wr     <= ~wr_p;
    endtask
    initial begin
        {ale_hi, ale_lo, cs, rd, wr, endian, ble, ad_o, ad_en, dhi_o, dhi_en} = '0;
    end
    // polarities, strobe scheme and upper-lane keeping
    task automatic setp(input logic [5:0] p);
        {ale_p, cs_p, rd_p, wr_p, rw_m, keep_hi} = p;
        @(posedge clk);
        idle();
    endtask
    // one latch phase; select drops only after the strobe, so qualification holds
    task automatic lat(input logic hi, input logic [15:0] v, input logic e, input logic c);
        @(posedge clk);
        ad_o   <= v;
        ad_en  <= 2'h3;
        endian <= e;
        cs     <= c ? cs_p : ~cs_p;
        @(posedge clk);
        if (hi) ale_hi <= ale_p;
        else ale_lo <= ale_p;
        repeat (4) @(posedge clk);
        ale_hi <= ~ale_p;
        ale_lo <= ~ale_p;
        repeat (3) @(posedge clk);
        idle();
        ad_o  <= ~v;
        ad_en <= 2'h0;
        repeat (3) @(posedge clk);
    endtask
    // start a data phase; byte lane enables wiggle on purpose
    task automatic go(input logic w, input logic [15:0] d);
        @(posedge clk);
        cs     <= cs_p;
        ble    <= ~ble;
        rd     <= (w == rw_m) ? rd_p : ~rd_p;
        wr     <= (w | rw_m) ? wr_p : ~wr_p;
        ad_o   <= w ? d : ad_o;
        ad_en  <= {w | keep_hi, w};
        dhi_o  <= d[15:8];
        dhi_en <= w;
    endtask
    // end the phase: strobe first, then select and data released to inverse
    task automatic stop();
        @(posedge clk);
        wr <= ~wr_p;
        rd <= rw_m ? rd : ~rd_p;
        repeat (2) @(posedge clk);
        idle();
        ad_o   <= ~ad_o;
        ad_en  <= 2'h0;
        dhi_o  <= ~dhi_o;
        dhi_en <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule

// [dv/mhb_bench.sv]
// mhb_bench: self-checking bench for mhb_top, host model on its pins.
// assumes: mhb_pkg, mhb_top, checker and host model compiled first.
`timescale 1ns/1ps
module mhb_bench
    import mhb_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0;
    logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [3:0]  wb_sel = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
    logic        wb_ack, dhi_oe, hold_out, hold_oe, h_dhi_en;
    logic        ale_hi, ale_lo, cs, rd, wr, endian;
    logic [15:0] ad_out, h_ad, ad_in;
    logic [1:0]  ad_oe, h_en, ble;
    logic [7:0]  dhi_out, h_dhi, dhi_in;
    int          err_count = 0, num_checks = 0;

    always #5 clk = ~clk;
    // device drive wins a lane; released host lanes already show the inverse
    assign ad_in = {ad_oe[1] ? ad_out[15:8] : h_ad[15:8], ad_oe[0] ? ad_out[7:0] : h_ad[7:0]};
    assign dhi_in      = dhi_oe ? dhi_out : h_dhi;

    mhb_top dut (.CLOCK(clk), .NRST(rst_n), .WB_CYC(wb_cyc), .WB_STB(wb_stb), .WB_WE(wb_we),
        .WB_ADR(wb_adr), .WB_SEL(wb_sel), .WB_DAT_I(wb_dat_i), .WB_DAT_O(wb_dat_o),
        .WB_ACK(wb_ack), .AD_IN(ad_in), .AD_OUT(ad_out), .AD_OE(ad_oe), .DHI_IN(dhi_in),
        .DHI_OUT(dhi_out), .DHI_OE(dhi_oe), .ADDRESS_LATCH_HIGH_STROBE(ale_hi),
        .ADDRESS_LATCH_LOW_STROBE(ale_lo), .CS(cs), .RD(rd), .WR(wr),
        .BYTE_LANE_ENABLES(ble), .ENDIAN_SEL(endian), .HOLD_OUT(hold_out), .HOLD_OE(hold_oe));
    mhb_host host (.clk(clk), .ale_hi(ale_hi), .ale_lo(ale_lo), .cs(cs), .rd(rd), .wr(wr),
        .endian(endian), .ble(ble), .ad_o(h_ad), .ad_en(h_en), .dhi_o(h_dhi),
        .dhi_en(h_dhi_en));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // host and device never drive one lane at once; a clash means a wrong enable
    always @(posedge clk) begin
        if (rst_n && {ad_oe & h_en, dhi_oe & h_dhi_en} != 3'h0) begin
            chk({29'h0, ad_oe & h_en, dhi_oe & h_dhi_en}, 32'h0);
        end
    end
    // classic single wishbone cycle; read data taken at the ack edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'hf;
        wb_dat_i <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        rdat = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 20) begin
            err_count++;
            wrap_up();
        end
    endtask
    // host read: {ad_oe, dhi_oe, low lane, upper lane}
    task automatic hrd(input logic [18:0] e);
        host.go(1'b0, 16'h0000);
        repeat (8) @(posedge clk);
        chk({13'h0, ad_oe, dhi_oe, ad_out[7:0],
            dhi_oe ? dhi_out : (ad_oe[1] ? ad_out[15:8] : 8'h00)}, {13'h0, e});
        host.stop();
    endtask
    task automatic hwr(input logic [15:0] d);
        host.go(1'b1, d);
        repeat (6) @(posedge clk);
        host.stop();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        wb(1'b0, MHB_OFS_CONFIG, 32'h0);
        chk(rdat, 32'h0000_001e);
        chk({30'h0, hold_oe, hold_out}, 32'h1);
        wb(1'b1, MHB_OFS_CONFIG, 32'hffff_fe1f);
        repeat (2) @(posedge clk);
        chk({30'h0, hold_oe, hold_out}, 32'h2);
        wb(1'b0, MHB_OFS_CONFIG, 32'h0);
        chk(rdat, 32'h0000_021f);
        wb(1'b0, 8'hfc, 32'h0);
        chk(rdat, 32'h0);
        wb(1'b1, MHB_OFS_CONFIG, 32'h21e);
        repeat (2) @(posedge clk);
        chk({30'h0, hold_oe, hold_out}, 32'h3);
        wb(1'b1, 8'h44, 32'h4433_2211);
        $display("t_regs done");
    endtask
    task automatic t_dual8();
        host.lat(1'b1, 16'h0001, 1'b0, 1'b1);
        host.lat(1'b0, 16'h0005, 1'b0, 1'b1);
        hrd({2'h1, 1'b0, 8'h22, 8'h00});
        host.lat(1'b0, 16'h0007, 1'b0, 1'b1);
        hrd({2'h1, 1'b0, 8'h44, 8'h00});
        hrd({2'h1, 1'b0, 8'h44, 8'h00});
        hwr(16'h7799);
        host.lat(1'b0, 16'h0004, 1'b0, 1'b1);
        hwr(16'h0088);
        wb(1'b0, 8'h44, 32'h0);
        chk(rdat, 32'h9933_2288);
        wb(1'b0, MHB_OFS_STATUS, 32'h0);
        chk(rdat, 32'h0000_0104);
        $display("t_dual8 done");
    endtask
    task automatic t_dual16();
        wb(1'b1, MHB_OFS_CONFIG, 32'h31e);
        host.lat(1'b0, 16'h0006, 1'b0, 1'b1);
        host.lat(1'b1, 16'h0002, 1'b1, 1'b1);
        hrd({2'h1, 1'b1, 8'h88, 8'h22});
        wb(1'b0, MHB_OFS_STATUS, 32'h0);
        chk(rdat, 32'h0001_0206);
        host.lat(1'b0, 16'h0004, 1'b0, 1'b1);
        hwr(16'h5566);
        host.lat(1'b0, 16'h0006, 1'b0, 1'b1);
        hrd({2'h1, 1'b1, 8'h33, 8'h99});
        wb(1'b0, 8'h44, 32'h0);
        chk(rdat, 32'h9933_5566);
        $display("t_dual16 done");
    endtask
    task automatic t_single();
        wb(1'b1, MHB_OFS_CONFIG, 32'h29e);
        host.setp(6'b111101);
        host.lat(1'b0, 16'h0305, 1'b0, 1'b1);
        hrd({2'h1, 1'b0, 8'h55, 8'h00});
        wb(1'b0, MHB_OFS_STATUS, 32'h0);
        chk(rdat, 32'h0000_0305);
        wb(1'b1, MHB_OFS_CONFIG, 32'h39e);
        host.setp(6'b111100);
        hrd({2'h3, 1'b0, 8'h66, 8'h55});
        $display("t_single done");
    endtask
    task automatic t_pol();
        wb(1'b1, MHB_OFS_CONFIG, 32'h264);
        host.setp(6'b010010);
        host.lat(1'b0, 16'h0007, 1'b0, 1'b0);
        wb(1'b0, MHB_OFS_STATUS, 32'h0);
        chk(rdat, 32'h0000_0305);
        host.lat(1'b0, 16'h0006, 1'b0, 1'b1);
        hrd({2'h1, 1'b0, 8'h33, 8'h00});
        hwr(16'h00aa);
        wb(1'b0, 8'h44, 32'h0);
        chk(rdat, 32'h99aa_5566);
        wb(1'b0, MHB_OFS_COUNT, 32'h0);
        chk(rdat, 32'h0004_0008);
        $display("t_pol done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_dual8();
        t_dual16();
        t_single();
        t_pol();
        wrap_up();
    end
endmodule
